/* hdl/spv_device.sv */
module spv_device
    import spv_pkg::*;
#(
    parameter spv_variant_e VARIANT = SPV_V96K,
    parameter int MEM_WORDS = 256
) (
    // System side
    input wire logic clock,
    input wire logic resetn,
    // Link
    spv_link_if.device link,
    // Configuration and I/O pins
    input wire logic low_volt_prog_allow,
    input wire logic [1:0] boot_block_size_sel,
    output logic prog_mode,
    output logic gpio_tristate,
    output logic entry_pin_is_gpio,
    // Core, written table latch, programming events
    output logic core_insn_valid,
    output logic [15:0] core_insn,
    input wire logic [7:0] table_latch,
    output logic prog_start,
    output logic [2:0] prot_block,
    output logic in_boot_block
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [21:0] mem_top(input spv_variant_e v);
        case (v)
            SPV_V96K: mem_top = MEM_TOP_96K;
            SPV_V32K: mem_top = MEM_TOP_32K;
            SPV_V24K: mem_top = MEM_TOP_24K;
            default: mem_top = MEM_TOP_8K;
        endcase
    endfunction

    function automatic logic [21:0] blk_size(input spv_variant_e v);
        case (v)
            SPV_V96K: blk_size = BLK_16K;
            SPV_V8K: blk_size = BLK_4K;
            default: blk_size = BLK_8K;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Mode entry on the system clock, master clear synchronised
    // ------------------------------------------------------------------
    logic [2:0] mclr_sync_ff;
    logic [2:0] pgm_sync_ff;
    logic mode_ff;

    // Pins pass three flip-flops; a change counts when stages two and three agree.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            mclr_sync_ff <= 3'h0;
            pgm_sync_ff <= 3'h0;
        end else begin
            mclr_sync_ff <= {mclr_sync_ff[1:0], link.master_clear_pin};
            pgm_sync_ff <= {pgm_sync_ff[1:0], link.low_volt_entry_pin};
        end
    end

    // Program mode entered only when allowed; left when master clear falls.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            mode_ff <= 1'b0;
        end else if (mclr_sync_ff[1] == mclr_sync_ff[2]) begin
            if (!mclr_sync_ff[2]) begin
                mode_ff <= 1'b0;
            end else if (!mode_ff && pgm_sync_ff[2] && pgm_sync_ff[1]
                         && low_volt_prog_allow) begin
                mode_ff <= 1'b1;
            end
        end
    end

    assign prog_mode = mode_ff;
    assign gpio_tristate = mode_ff;
    assign entry_pin_is_gpio = !mode_ff;

    // ------------------------------------------------------------------
    // Link domain: shift engine on the programmer's clock
    // ------------------------------------------------------------------
    logic [4:0] cnt_ff;
    logic [3:0] cmd_ff;
    logic [15:0] opnd_ff;
    logic [7:0] out_ff;
    logic out_en_ff;
    logic done_tgl_ff;
    logic [3:0] dcmd_ff;
    logic [15:0] dopnd_ff;
    logic lk_enable;
    logic rx_bit;

    assign rx_bit = link.line_host_oe ? link.line_host_out : 1'b0;

    // The link clock stops outside frames, so a mode level synchronised on it would
    // lose the first bits; the entry pin and the allow bit are steady before it runs.
    assign lk_enable = link.low_volt_entry_pin && low_volt_prog_allow;

    // Bits latched on the falling edge, LSb first, 20 to a frame.
    always_ff @(negedge link.prog_serial_clock or negedge link.master_clear_pin) begin
        if (!link.master_clear_pin) begin
            cnt_ff <= CNT_RST;
            cmd_ff <= 4'h0;
            opnd_ff <= 16'h0000;
            done_tgl_ff <= 1'b0;
            dcmd_ff <= 4'h0;
            dopnd_ff <= 16'h0000;
        end else if (lk_enable) begin
            if (cnt_ff < 5'(CMD_BITS)) begin
                cmd_ff <= {rx_bit, cmd_ff[3:1]};
            end else begin
                opnd_ff <= {rx_bit, opnd_ff[15:1]};
            end
            if (cnt_ff == CNT_LAST) begin
                cnt_ff <= CNT_RST;
                dcmd_ff <= cmd_ff;
                dopnd_ff <= {rx_bit, opnd_ff[15:1]};
                done_tgl_ff <= !done_tgl_ff;
            end else begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end

    // Output half driven on rising edges after the eighth operand bit.
    always_ff @(posedge link.prog_serial_clock or negedge link.master_clear_pin) begin
        if (!link.master_clear_pin) begin
            out_ff <= 8'h00;
            out_en_ff <= 1'b0;
        end else if (cmd_ff == SPV_SHIFT_OUT && cnt_ff == CNT_OUT_START) begin
            out_ff <= table_latch;
            out_en_ff <= 1'b1;
        end else if (out_en_ff && cnt_ff > CNT_OUT_START) begin
            out_ff <= {1'b0, out_ff[7:1]};
        end else if (cnt_ff < CNT_OUT_START) begin
            out_en_ff <= 1'b0;
        end
    end

    // Turnaround: the device drives first after the programmer's pause.
    assign link.line_dev_out = out_ff[0];
    // The line is released at the last latching edge, as the clock then stops.
    assign link.line_dev_oe = out_en_ff && cnt_ff >= CNT_OUT_START;

    // ------------------------------------------------------------------
    // Completed frame crosses back by toggle
    // ------------------------------------------------------------------
    logic [2:0] tgl_sync_ff;
    logic go;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tgl_sync_ff <= 3'h0;
        end else begin
            tgl_sync_ff <= {tgl_sync_ff[1:0], done_tgl_ff};
        end
    end
    assign go = tgl_sync_ff[2] != tgl_sync_ff[1];

    // ------------------------------------------------------------------
    // Decoded action on the system clock
    // ------------------------------------------------------------------
    logic [21:0] ptr_ff;
    logic [21:0] top;
    logic [15:0] mem [MEM_WORDS];
    logic [7:0] rd_byte;
    logic [21:0] ea;
    logic [21:0] boot_top;

    assign top = mem_top(VARIANT);
    assign ea = (dcmd_ff == SPV_TRD_PREINC) ? ptr_ff + 22'h1 : ptr_ff;

    // Pointer updates for the auto-increment and post-decrement table commands.
    always_ff @(posedge clock) begin
        if (!resetn || !mode_ff) begin
            ptr_ff <= PTR_RST;
        end else if (go) begin
            case (dcmd_ff)
                SPV_TRD_POSTINC: ptr_ff <= (ptr_ff == top) ? PTR_RST : ptr_ff + 22'h1;
                SPV_TRD_POSTDEC: ptr_ff <= ptr_ff - 22'h1;
                SPV_TRD_PREINC: ptr_ff <= ptr_ff + 22'h1;
                SPV_TWR_INC2, SPV_TWR_PROG_INC2: ptr_ff <= ptr_ff + 22'h2;
                default: ptr_ff <= ptr_ff;
            endcase
        end
    end

    // Read byte from the small array; unimplemented space reads zero.
    always_comb begin
        rd_byte = 8'h00;
        if (ea <= top && ea[21:1] < 21'(MEM_WORDS)) begin
            rd_byte = ea[0] ? mem[ea[8:1]][15:8] : mem[ea[8:1]][7:0];
        end
    end

    // Table writes store the operand low byte into the array.
    always_ff @(posedge clock) begin
        if (go && dcmd_ff[3:2] == 2'b11 && ptr_ff <= top
            && ptr_ff[21:1] < 21'(MEM_WORDS)) begin
            if (ptr_ff[0]) begin
                mem[ptr_ff[8:1]][15:8] <= dopnd_ff[7:0];
            end else begin
                mem[ptr_ff[8:1]][7:0] <= dopnd_ff[7:0];
            end
        end
    end

    // Core instruction, programming start and read result.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            core_insn_valid <= 1'b0;
            core_insn <= 16'h0000;
            prog_start <= 1'b0;
        end else begin
            core_insn_valid <= go && dcmd_ff == SPV_CORE_INSN;
            prog_start <= go && (dcmd_ff == SPV_TWR_PROG_INC2
                                 || dcmd_ff == SPV_TWR_PROG);
            if (go && dcmd_ff == SPV_CORE_INSN) begin
                core_insn <= dopnd_ff;
            end else if (go && dcmd_ff[3:2] == 2'b10) begin
                core_insn <= {8'h00, rd_byte};
            end
        end
    end

    // Protection block and boot region of the current pointer.
    always_comb begin
        boot_top = BOOT_TOP_SMALL;
        if (VARIANT == SPV_V96K) begin
            case (boot_block_size_sel)
                BBSZ_1KW: boot_top = BOOT_1KW - 22'h1;
                BBSZ_2KW: boot_top = BOOT_2KW - 22'h1;
                default: boot_top = BOOT_4KW - 22'h1;
            endcase
        end
        in_boot_block = ptr_ff <= boot_top && ptr_ff <= top;
        prot_block = 3'((ptr_ff / blk_size(VARIANT)));
        if (ptr_ff > top) begin
            prot_block = 3'h7;
        end
    end
endmodule

/* hdl/spv_host.sv */
module spv_host
    import spv_pkg::*;
(
    // System side
    input wire logic clock,
    input wire logic resetn,
    // Link
    spv_link_if.host link,
    // User commands
    input wire logic enter,
    input wire logic leave,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [3:0] req_cmd,
    input wire logic [15:0] req_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data
);
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SH_IDLE = 3'b000,
        SH_ENTRY = 3'b001,
        SH_READY = 3'b010,
        SH_SHIFT = 3'b011,
        SH_TURN = 3'b100,
        SH_READ = 3'b101
    } sh_state_e;

    sh_state_e st_ff;
    logic [19:0] sr_ff;
    logic [4:0] bit_ff;
    logic [7:0] div_ff;
    logic sck_ff;
    logic [7:0] rx_ff;
    logic [3:0] cmd_ff;
    logic read_cmd;

    // The command is kept apart, since the shift register moves during the frame.
    assign read_cmd = cmd_ff == SPV_SHIFT_OUT;
    assign req_ready = st_ff == SH_READY;
    assign link.prog_serial_clock = sck_ff;
    assign link.line_host_out = sr_ff[0];
    assign link.line_host_oe = st_ff != SH_READ && st_ff != SH_TURN;

    // Sequencer; the serial clock is a divided copy of the system clock.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_ff <= SH_IDLE;
            sr_ff <= 20'h00000;
            bit_ff <= 5'h00;
            div_ff <= 8'h00;
            sck_ff <= 1'b0;
            rx_ff <= 8'h00;
            cmd_ff <= 4'h0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            link.low_volt_entry_pin <= 1'b0;
            link.master_clear_pin <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (st_ff)
                SH_IDLE: if (enter) begin
                    link.low_volt_entry_pin <= 1'b1;
                    sr_ff <= 20'h00000; // Data line held low for entry.
                    div_ff <= 8'h00;
                    st_ff <= SH_ENTRY;
                end
                SH_ENTRY: begin
                    div_ff <= div_ff + 8'h01;
                    if (div_ff == 8'(TURN_CYC)) begin
                        link.master_clear_pin <= 1'b1;
                        st_ff <= SH_READY;
                    end
                end
                SH_READY: if (leave) begin
                    link.master_clear_pin <= 1'b0;
                    link.low_volt_entry_pin <= 1'b0;
                    st_ff <= SH_IDLE;
                end else if (req_valid) begin
                    sr_ff <= {req_data, req_cmd};
                    cmd_ff <= req_cmd;
                    bit_ff <= 5'h00;
                    div_ff <= 8'h00;
                    st_ff <= SH_SHIFT;
                end
                SH_SHIFT, SH_READ: begin
                    div_ff <= div_ff + 8'h01;
                    if (div_ff == 8'(LINK_DIV_HALF - 1)) begin
                        sck_ff <= 1'b1;
                        if (st_ff == SH_SHIFT && bit_ff != 5'h00) begin
                            sr_ff <= {1'b0, sr_ff[19:1]};
                        end
                    end else if (div_ff == 8'(2 * LINK_DIV_HALF - 1)) begin
                        sck_ff <= 1'b0;
                        div_ff <= 8'h00;
                        bit_ff <= bit_ff + 5'h01;
                        if (st_ff == SH_READ) begin
                            rx_ff <= {link.line_dev_out, rx_ff[7:1]};
                        end
                        if (bit_ff == CNT_LAST) begin
                            st_ff <= SH_READY;
                            rsp_valid <= st_ff == SH_READ;
                            rsp_data <= {link.line_dev_out, rx_ff[7:1]};
                        end else if (bit_ff == 5'(CMD_BITS + HALF_BITS - 1)
                                     && read_cmd) begin
                            st_ff <= SH_TURN;
                        end
                    end
                end
                SH_TURN: begin
                    div_ff <= div_ff + 8'h01;
                    if (div_ff == 8'(TURN_CYC)) begin
                        div_ff <= 8'h00;
                        st_ff <= SH_READ;
                    end
                end
                default: st_ff <= SH_IDLE;
            endcase
        end
    end
endmodule

/* hdl/spv_link_if.sv */
interface spv_link_if;
    // Serial clock, data line pieces, entry pins.
    logic prog_serial_clock;
    logic line_dev_out;
    logic line_dev_oe;
    logic line_host_out;
    logic line_host_oe;
    logic low_volt_entry_pin;
    logic master_clear_pin;
    wire prog_serial_line = line_dev_oe ? line_dev_out :
                            (line_host_oe ? line_host_out : 1'b0);

    modport device (
        input prog_serial_clock,
        input low_volt_entry_pin,
        input master_clear_pin,
        input line_host_out,
        input line_host_oe,
        output line_dev_out,
        output line_dev_oe
    );
    modport host (
        output prog_serial_clock,
        output low_volt_entry_pin,
        output master_clear_pin,
        output line_host_out,
        output line_host_oe,
        input line_dev_out,
        input line_dev_oe
    );
endinterface

/* hdl/spv_pkg.sv */
package spv_pkg;
    // ------------------------------------------------------------------
    // Transaction framing
    // ------------------------------------------------------------------
    localparam int CMD_BITS = 4;
    localparam int OPND_BITS = 16;
    localparam int XACT_BITS = 20;
    localparam int HALF_BITS = 8;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [4:0] CNT_LAST = 5'h13;
    localparam logic [4:0] CNT_OUT_START = 5'h0C;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SPV_CORE_INSN = 4'h0,
        SPV_SHIFT_OUT = 4'h2,
        SPV_TRD = 4'h8,
        SPV_TRD_POSTINC = 4'h9,
        SPV_TRD_POSTDEC = 4'hA,
        SPV_TRD_PREINC = 4'hB,
        SPV_TWR = 4'hC,
        SPV_TWR_INC2 = 4'hD,
        SPV_TWR_PROG_INC2 = 4'hE,
        SPV_TWR_PROG = 4'hF
    } spv_cmd_e;

    // ------------------------------------------------------------------
    // Memory layout
    // ------------------------------------------------------------------
    localparam int PTR_BITS = 22;
    localparam logic [21:0] PTR_RST = 22'h000000;
    localparam logic [21:0] MEM_TOP_96K = 22'h017FFF;
    localparam logic [21:0] MEM_TOP_32K = 22'h007FFF;
    localparam logic [21:0] MEM_TOP_24K = 22'h005FFF;
    localparam logic [21:0] MEM_TOP_8K = 22'h001FFF;
    localparam logic [21:0] BOOT_TOP_SMALL = 22'h0007FF;
    localparam logic [21:0] BLK_16K = 22'h004000;
    localparam logic [21:0] BLK_8K = 22'h002000;
    localparam logic [21:0] BLK_4K = 22'h001000;
    localparam logic [21:0] BOOT_1KW = 22'h000800;
    localparam logic [21:0] BOOT_2KW = 22'h001000;
    localparam logic [21:0] BOOT_4KW = 22'h002000;
    localparam logic [1:0] BBSZ_1KW = 2'h0;
    localparam logic [1:0] BBSZ_2KW = 2'h1;

    typedef enum logic [1:0] {
        SPV_V96K = 2'h0,
        SPV_V32K = 2'h1,
        SPV_V24K = 2'h2,
        SPV_V8K = 2'h3
    } spv_variant_e;

    // ------------------------------------------------------------------
    // Programmer timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int LINK_DIV_HALF = 4;
    localparam int TURN_NS = 100;
    localparam int TURN_CYC = (TURN_NS * CLK_MHZ + 999) / 1000;
endpackage

/* verification/spv_link_sva.sv */
// ----------------------------------------------------------------------
// Link protocol checker
// ----------------------------------------------------------------------
module spv_link_sva
    import spv_pkg::*;
(
    // System clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Link signals
    input wire logic prog_serial_clock,
    input wire logic line_dev_out,
    input wire logic line_dev_oe,
    input wire logic line_host_out,
    input wire logic line_host_oe,
    input wire logic low_volt_entry_pin,
    input wire logic master_clear_pin,
    input wire logic prog_serial_line
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    logic [4:0] rise_cnt_ff;
    logic [3:0] dev_bits_ff;

    // Counts link clock rises inside a frame, wrapping at the frame length.
    always_ff @(posedge clock) begin
        if (!resetn || !master_clear_pin) begin
            rise_cnt_ff <= CNT_RST;
        end else if ($rose(prog_serial_clock)) begin
            rise_cnt_ff <= (rise_cnt_ff == CNT_LAST) ? CNT_RST : rise_cnt_ff + 5'h01;
        end
    end

    // Counts the rising edges that launch device bits while it drives the line.
    always_ff @(posedge clock) begin
        if (!resetn || !line_dev_oe) begin
            dev_bits_ff <= 4'h0;
        end else if ($rose(prog_serial_clock)) begin
            dev_bits_ff <= dev_bits_ff + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_NO_CONTENTION: assert property (!(line_dev_oe && line_host_oe))
        else $error("both ends drive the data line");
    AST_ENTRY_ORDER: assert property ($rose(master_clear_pin)
        |-> !prog_serial_clock && !prog_serial_line && $past(low_volt_entry_pin))
        else $error("entry order broken");
    AST_CLK_IDLE_OUT_OF_MODE: assert property (!master_clear_pin |-> !prog_serial_clock)
        else $error("link clock runs outside program mode");
    AST_HOST_DATA_HELD_AT_FALL: assert property ($fell(prog_serial_clock) && line_host_oe
        |-> $stable(line_host_out))
        else $error("host data moved at the latching edge");
    AST_FRAME_20_CLOCKS: assert property ($fell(master_clear_pin) |-> rise_cnt_ff == CNT_RST)
        else $error("mode left in mid frame");
    AST_OUT_HALF_8_BITS: assert property ($fell(line_dev_oe) |-> dev_bits_ff == 4'h8)
        else $error("device output half is not eight bits");
    AST_OUT_STARTS_AT_BIT12: assert property ($rose(line_dev_oe)
        |-> rise_cnt_ff == CNT_OUT_START && prog_serial_clock)
        else $error("device output starts at the wrong bit");
    AST_DEV_QUIET_OUT_OF_MODE: assert property (!master_clear_pin && !$past(master_clear_pin)
        |-> !line_dev_oe)
        else $error("device drives outside program mode");

    cover property ($rose(master_clear_pin));
    cover property ($rose(line_dev_oe));
    cover property ($fell(master_clear_pin));
endmodule

/* verification/tb_serial_program_verify_port.sv */
// ----------------------------------------------------------------------
// Testbench for both link ends
// ----------------------------------------------------------------------
module tb_serial_program_verify_port
    import spv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, resetn, enter, leave, req_valid, low_volt_prog_allow;
    logic req_ready, rsp_valid, prog_mode, gpio_tristate, entry_pin_is_gpio;
    logic core_insn_valid, prog_start, in_boot_block;
    logic [3:0] req_cmd;
    logic [15:0] req_data, core_insn, last_core;
    logic [1:0] boot_block_size_sel;
    logic [7:0] table_latch, rsp_data;
    logic [2:0] prot_block;
    logic wire_bits[$];
    int failures, samples_checked, cycles, core_seen, prog_seen, k;
    // Each entry is command, operand, then a compare flag and the expected byte.
    localparam logic [28:0] SEQ [13] = '{
        {4'hC, 16'h0010, 9'h000},
        {4'h9, 16'h0000, 9'h110},
        {4'hD, 16'h0021, 9'h000},
        {4'hE, 16'h0043, 9'h000},
        {4'hF, 16'h0055, 9'h000},
        {4'h8, 16'h0000, 9'h155},
        {4'hA, 16'h0000, 9'h155},
        {4'hA, 16'h0000, 9'h000},
        {4'hA, 16'h0000, 9'h143},
        {4'hB, 16'h0000, 9'h143},
        {4'hA, 16'h0000, 9'h143},
        {4'hA, 16'h0000, 9'h000},
        {4'h8, 16'h0000, 9'h121}
    };

    spv_link_if i_spv_link_if ();
    spv_host i_spv_host (.clock(clock), .resetn(resetn), .link(i_spv_link_if.host),
        .enter(enter), .leave(leave), .req_valid(req_valid), .req_ready(req_ready),
        .req_cmd(req_cmd), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    spv_device i_spv_device (.clock(clock), .resetn(resetn), .link(i_spv_link_if.device),
        .low_volt_prog_allow(low_volt_prog_allow), .boot_block_size_sel(boot_block_size_sel),
        .prog_mode(prog_mode), .gpio_tristate(gpio_tristate),
        .entry_pin_is_gpio(entry_pin_is_gpio), .core_insn_valid(core_insn_valid),
        .core_insn(core_insn), .table_latch(table_latch), .prog_start(prog_start),
        .prot_block(prot_block), .in_boot_block(in_boot_block));
    spv_link_sva i_spv_link_sva (.clock(clock), .resetn(resetn),
        .prog_serial_clock(i_spv_link_if.prog_serial_clock),
        .line_dev_out(i_spv_link_if.line_dev_out), .line_dev_oe(i_spv_link_if.line_dev_oe),
        .line_host_out(i_spv_link_if.line_host_out), .line_host_oe(i_spv_link_if.line_host_oe),
        .low_volt_entry_pin(i_spv_link_if.low_volt_entry_pin),
        .master_clear_pin(i_spv_link_if.master_clear_pin),
        .prog_serial_line(i_spv_link_if.prog_serial_line));

    // System clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Counts pulses and cuts a hung run short.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (core_insn_valid === 1'b1) begin
            core_seen <= core_seen + 1;
            last_core <= core_insn;
        end
        if (prog_start === 1'b1) prog_seen <= prog_seen + 1;
        if (cycles == 40000) begin
            failures++;
            print_verdict();
        end
    end

    // Collects the line level at every latching edge in program mode.
    always @(negedge i_spv_link_if.prog_serial_clock) begin
        if (i_spv_link_if.master_clear_pin === 1'b1) wire_bits.push_back(i_spv_link_if.prog_serial_line);
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic bit pick(input int which);
        case (which)
            0: return req_ready === 1'b1;
            1: return rsp_valid === 1'b1;
            2: return prog_mode === 1'b1;
            default: return req_ready === 1'b0;
        endcase
    endfunction

    // Waits on falling clock edges, where outputs have settled, under a bound.
    task automatic wait_neg(input int which);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (!pick(which) && n < 3000);
        if (n >= 3000) begin
            check("wait", 20'h1, 20'h0);
            print_verdict();
        end
    endtask

    task automatic enter_mode();
        @(posedge clock);
        enter <= 1'b1;
        wait_neg(0);
        @(posedge clock);
        enter <= 1'b0;
    endtask

    task automatic leave_mode();
        @(posedge clock);
        leave <= 1'b1;
        wait_neg(3);
        @(posedge clock);
        leave <= 1'b0;
        repeat (40) @(posedge clock);
    endtask

    // One frame; exp[8] asks for the returned byte to be compared.
    task automatic xact(input logic [3:0] cmd, input logic [15:0] data, input logic [8:0] exp);
        logic [19:0] got;
        logic [19:0] want;
        logic rd;
        rd = cmd == 4'h2;
        want = rd ? {exp[7:0], data[7:0], cmd} : {data, cmd};
        wire_bits = {};
        @(posedge clock);
        req_cmd <= cmd;
        req_data <= data;
        req_valid <= 1'b1;
        wait_neg(0);
        @(posedge clock);
        req_valid <= 1'b0;
        wait_neg(rd ? 1 : 0);
        if (rd && exp[8] === 1'b1) check("read byte", {12'h000, exp[7:0]}, {12'h000, rsp_data});
        repeat (6) @(negedge clock);
        if (cmd[3:2] == 2'b10 && exp[8] === 1'b1) begin
            check("table byte", {12'h000, exp[7:0]}, {4'h0, core_insn});
        end
        for (int i = 0; i < 20; i++) got[i] = (i < wire_bits.size()) ? wire_bits[i] : 1'bx;
        if (rd && exp[8] !== 1'b1) got[19:12] = want[19:12];
        check("frame bits", want, got);
        check("frame length", 20'h00014, 20'(wire_bits.size()));
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        {enter, leave, req_valid, low_volt_prog_allow} = 4'h0;
        req_cmd = 4'h0;
        req_data = 16'h0000;
        boot_block_size_sel = 2'h0;
        table_latch = 8'h5A;
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        core_seen = 0;
        prog_seen = 0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        check("gpio before entry", 20'h1, {19'h0, entry_pin_is_gpio});
        enter_mode();
        repeat (40) @(posedge clock);
        check("refused entry", 20'h0, {19'h0, prog_mode});
        leave_mode();
        low_volt_prog_allow <= 1'b1;
        enter_mode();
        wait_neg(2);
        check("tristate", 20'h1, {19'h0, gpio_tristate});
        check("entry pin gpio", 20'h0, {19'h0, entry_pin_is_gpio});
        check("boot block", 20'h1, {19'h0, in_boot_block});
        check("protection block", 20'h0, {17'h0, prot_block});
        xact(4'h0, 16'h3C40, 9'h000);
        repeat (8) @(posedge clock);
        check("core count", 20'h1, 20'(core_seen));
        check("core word", 20'h03C40, {4'h0, last_core});
        xact(4'h2, 16'h0000, 9'h15A);
        for (k = 0; k < 13; k++) xact(SEQ[k][28:25], SEQ[k][24:9], SEQ[k][8:0]);
        repeat (8) @(posedge clock);
        check("program starts", 20'h2, 20'(prog_seen));
        leave_mode();
        check("mode left", 20'h0, {19'h0, prog_mode});
        enter_mode();
        wait_neg(2);
        xact(4'hA, 16'h0000, 9'h110);
        xact(4'h8, 16'h0000, 9'h100);
        check("unimplemented block", 20'h7, {17'h0, prot_block});
        print_verdict();
    end
endmodule
